// File: core/smbus_temp_sensor_regs.sv
// smbus slave register block of a continuously converting temperature sensor
//
// Contract
// - slave only: byte/word writes and reads
// - conversions run continuously, latest result always readable
// - each fitted address input sets one address bit, unfitted inputs are ignored
// - two, three or four address inputs
// - first written byte loads the register pointer
// - temperature 13-bit two's complement, 1/16 degree
// - temperature register read-only, holds latest result
// - no-limit variant: three low bits unused
// - limit variant: two status bits, bit two unused
// - 8-bit config: timeout disable, shutdown; fault queue bit stored but has no effect
// - limit variant adds high, low, hysteresis registers
// - data line pulled low only, clock input only
// - alarm and overtemp outputs open-drain, pull low
// - shutdown stops conversions, bus stays usable
`timescale 1ns/100ps
`default_nettype none
`include "smbus_temp_defines.svh"
module smbus_temp_sensor_regs #(
  parameter int         ADDR_PINS   = 4,           // address inputs fitted: 2, 3 or 4
  parameter bit         HAS_LIMITS  = 1'b0,        // limit registers and alarm outputs
  parameter logic [6:0] BASE_ADDR   = 7'h48,       // fixed address bits above the pins
  parameter int         TIMEOUT_CYC = `TIMEOUT_CYC,  // clock-low timeout in cycles
  parameter int         CONV_CYC    = `CONV_CYC      // conversion period in cycles
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,                 // serial clock, input only
  input  wire logic        sda_in,                 // serial data line level
  output logic             sda_out,                // always low when enabled
  output logic             sda_oe,                 // high while pulling data low
  input  wire logic        addr_select_bit_zero,
  input  wire logic        addr_select_bit_one,
  input  wire logic        addr_select_bit_two,
  input  wire logic        addr_select_bit_three,
  input  wire logic [12:0] adc_code,               // converter result, signed 1/16 degree
  output logic             conv_start,             // pulse: converter samples now
  output logic             alarm_out,              // always low when enabled
  output logic             alarm_oe,               // high while alarm is asserted
  output logic             overtemp_shutdown_out,  // always low when enabled
  output logic             overtemp_oe             // high while over temperature
);
  generate
    if (ADDR_PINS < 2 || ADDR_PINS > 4) begin : g_bad_pins
      $error("ADDR_PINS must be 2, 3 or 4");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // addressing
  localparam logic [6:0] ADDR_MASK = 7'((1 << ADDR_PINS) - 1);
  logic [3:0] pins;     // address inputs as a vector
  logic [6:0] my_addr;  // resolved slave address
  assign pins    = {addr_select_bit_three, addr_select_bit_two,
                    addr_select_bit_one, addr_select_bit_zero};
  // fitted pins replace the low address bits, unfitted ones are ignored
  assign my_addr = (BASE_ADDR & ~ADDR_MASK) | ({3'h0, pins} & ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // bus line edges (inputs are synchronous, one register is enough)
  logic scl_q;  // serial clock one cycle ago
  logic sda_q;  // serial data one cycle ago
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_in && !scl_q;
  assign scl_fall  = !scl_in && scl_q;
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop  = scl_in && scl_q && !sda_q && sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // registers and timebases
  smbus_temp_pkg::slave_state_t state_r;
  logic [7:0]  config_r;     // configuration_control
  logic [15:0] temp_r;       // temperature_result
  logic [15:0] high_limit;   // high limit register
  logic [15:0] low_limit;    // low limit register
  logic [15:0] hysteresis_limit;
  logic [2:0]  pointer_r;    // register select
  logic [3:0]  bit_cnt_r;    // bits seen in the current byte
  logic [7:0]  rx_r;         // received shift register
  logic [7:0]  tx_r;         // transmit shift register
  logic        rw_r;         // 1 for a read transfer
  logic        byte_idx_r;   // 0 for the first data byte, 1 after
  logic        nack_r;       // master refused the last read byte
  logic        hi_flag_r;    // status: at or above high limit
  logic        lo_flag_r;    // status: below low limit
  logic        ovt_r;        // over temperature with hysteresis
  logic        timeout;      // clock held low too long
  logic        shutdown;

  assign shutdown = config_r[`CFG_SHUTDOWN];

  // conversion timebase halts in shutdown; the bus logic keeps running
  tick_divider #(.PERIOD(CONV_CYC)) u_conv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (!shutdown),
    .tick    (conv_start)
  );

  // timeout counts only inside a transfer with the clock low
  tick_divider #(.PERIOD(TIMEOUT_CYC)) u_tmo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (state_r != smbus_temp_pkg::ST_IDLE && !scl_in
              && !config_r[`CFG_TMO_DIS]),
    .tick    (timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read byte selection
  function automatic logic [7:0] read_byte(input logic [2:0] ptr, input logic idx);
    logic [15:0] w;
    w = 16'h0000;
    case (ptr)
      `PTR_TEMP:   w = temp_r;
      `PTR_CONFIG: w = {config_r, 8'h00};  // 8-bit register in the first byte
      `PTR_HYST:   w = HAS_LIMITS ? hysteresis_limit : {`UNMAPPED_BYTE, `UNMAPPED_BYTE};
      `PTR_LOW:    w = HAS_LIMITS ? low_limit : {`UNMAPPED_BYTE, `UNMAPPED_BYTE};
      `PTR_HIGH:   w = HAS_LIMITS ? high_limit : {`UNMAPPED_BYTE, `UNMAPPED_BYTE};
      default:     w = {`UNMAPPED_BYTE, `UNMAPPED_BYTE};
    endcase
    read_byte = idx ? w[7:0] : w[15:8];  // most significant byte first
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // slave state machine; start and stop win from any state
  logic byte_done;  // falling clock after the eighth bit
  assign byte_done = scl_fall && (bit_cnt_r == 4'h8);

  // the ninth clock carries an acknowledge, not a data bit; counting it would
  // shift every later byte boundary one clock early
  logic ack_slot;  // state owns the acknowledge clock
  assign ack_slot = state_r inside {smbus_temp_pkg::ST_AACK, smbus_temp_pkg::ST_CACK,
                                    smbus_temp_pkg::ST_WACK, smbus_temp_pkg::ST_RACK};

  always_ff @(posedge clk) begin
    if (sys_rst || bus_stop || timeout) begin
      state_r <= smbus_temp_pkg::ST_IDLE;
    end else if (bus_start) begin
      state_r <= smbus_temp_pkg::ST_ADDR;
    end else if (scl_fall) begin
      case (state_r)
        smbus_temp_pkg::ST_ADDR:
          if (bit_cnt_r == 4'h8) begin
            // foreign address: stay off the bus until the next start
            state_r <= (rx_r[7:1] == my_addr) ? smbus_temp_pkg::ST_AACK
                                              : smbus_temp_pkg::ST_IDLE;
          end
        smbus_temp_pkg::ST_AACK:
          state_r <= rw_r ? smbus_temp_pkg::ST_RDAT : smbus_temp_pkg::ST_CMD;
        smbus_temp_pkg::ST_CMD:
          if (bit_cnt_r == 4'h8) begin
            state_r <= smbus_temp_pkg::ST_CACK;
          end
        smbus_temp_pkg::ST_CACK: state_r <= smbus_temp_pkg::ST_WDAT;
        smbus_temp_pkg::ST_WDAT:
          if (bit_cnt_r == 4'h8) begin
            state_r <= smbus_temp_pkg::ST_WACK;
          end
        smbus_temp_pkg::ST_WACK: state_r <= smbus_temp_pkg::ST_WDAT;
        smbus_temp_pkg::ST_RDAT:
          if (bit_cnt_r == 4'h8) begin
            state_r <= smbus_temp_pkg::ST_RACK;
          end
        smbus_temp_pkg::ST_RACK:
          state_r <= nack_r ? smbus_temp_pkg::ST_IDLE : smbus_temp_pkg::ST_RDAT;
        default: state_r <= smbus_temp_pkg::ST_IDLE;
      endcase
    end
  end

  // bit counter and receive shifter: sample on rising clock
  always_ff @(posedge clk) begin
    if (sys_rst || bus_start) begin
      bit_cnt_r <= 4'h0;
      rx_r      <= 8'h00;
    end else if (scl_rise && bit_cnt_r != 4'h8 && !ack_slot) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      rx_r      <= {rx_r[6:0], sda_in};
    end else if (byte_done) begin
      bit_cnt_r <= 4'h0;  // acknowledge slot is not counted, the state owns it
    end
  end

  // direction, pointer, data byte index and master acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rw_r       <= 1'b0;
      pointer_r  <= `PTR_TEMP;
      byte_idx_r <= 1'b0;
      nack_r     <= 1'b0;
    end else begin
      if (byte_done && state_r == smbus_temp_pkg::ST_ADDR) begin
        rw_r       <= rx_r[0];
        byte_idx_r <= 1'b0;
      end
      if (byte_done && state_r == smbus_temp_pkg::ST_CMD) begin
        pointer_r <= rx_r[2:0];
      end
      if (scl_fall && (state_r == smbus_temp_pkg::ST_WACK
                       || state_r == smbus_temp_pkg::ST_RACK)) begin
        byte_idx_r <= 1'b1;  // later bytes of a word or beyond
      end
      if (scl_rise && state_r == smbus_temp_pkg::ST_RACK) begin
        nack_r <= sda_in;
      end
    end
  end

  // transmit shifter: load on the falling clock that opens a read byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_r <= 8'hff;
    end else if (scl_fall && ((state_r == smbus_temp_pkg::ST_AACK && rw_r)
                             || (state_r == smbus_temp_pkg::ST_RACK && !nack_r))) begin
      tx_r <= read_byte(pointer_r, state_r == smbus_temp_pkg::ST_RACK);
    end else if (scl_fall && state_r == smbus_temp_pkg::ST_RDAT) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // data line: only ever pulled low, released otherwise
  assign sda_out = 1'b0;
  assign sda_oe  = (state_r == smbus_temp_pkg::ST_AACK) || (state_r == smbus_temp_pkg::ST_CACK)
                || (state_r == smbus_temp_pkg::ST_WACK)
                || (state_r == smbus_temp_pkg::ST_RDAT && !tx_r[7]);

  ////////////////////////////////////////////////////////////////////////////
  // register writes; temperature has no write path at all
  logic wr_done;  // a data byte has just been received
  assign wr_done = byte_done && state_r == smbus_temp_pkg::ST_WDAT;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_r <= `CFG_RESET;
    end else if (wr_done && !byte_idx_r && pointer_r == `PTR_CONFIG) begin
      config_r <= rx_r;
    end
  end

  // limit registers: msb byte first, committed when the lsb byte arrives
  logic [7:0] msb_hold_r;  // first byte of a word write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msb_hold_r       <= 8'h00;
      high_limit       <= `HIGH_RESET;
      low_limit        <= `LOW_RESET;
      hysteresis_limit <= `HYST_RESET;
    end else if (wr_done && !byte_idx_r) begin
      msb_hold_r <= rx_r;
    end else if (wr_done && HAS_LIMITS) begin
      case (pointer_r)
        `PTR_HIGH: high_limit       <= {msb_hold_r, rx_r[7:3], 3'h0};
        `PTR_LOW:  low_limit        <= {msb_hold_r, rx_r[7:3], 3'h0};
        `PTR_HYST: hysteresis_limit <= {msb_hold_r, rx_r[7:3], 3'h0};
        default:   msb_hold_r       <= msb_hold_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion result and status; only a conversion tick changes them
  logic signed [12:0] t_now;  // incoming result, signed
  assign t_now = $signed(adc_code);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_r    <= 16'h0000;
      hi_flag_r <= 1'b0;
      lo_flag_r <= 1'b0;
      ovt_r     <= 1'b0;
    end else if (conv_start) begin
      // flags are only meaningful in the limit variant
      hi_flag_r <= HAS_LIMITS && (t_now >= $signed(high_limit[15:3]));
      lo_flag_r <= HAS_LIMITS && (t_now < $signed(low_limit[15:3]));
      if (HAS_LIMITS && t_now >= $signed(high_limit[15:3])) begin
        ovt_r <= 1'b1;
      end else if (t_now < $signed(hysteresis_limit[15:3])) begin
        ovt_r <= 1'b0;
      end
      if (HAS_LIMITS) begin
        temp_r <= {adc_code, 1'b0,
                   t_now >= $signed(high_limit[15:3]),
                   t_now < $signed(low_limit[15:3])};
      end else begin
        temp_r <= {adc_code, 3'h0};
      end
    end
  end

  // alarm pins pull low only while asserted
  assign alarm_out             = 1'b0;
  assign alarm_oe              = hi_flag_r || lo_flag_r;
  assign overtemp_shutdown_out = 1'b0;
  assign overtemp_oe           = ovt_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_sda_owner;
    @(posedge clk) disable iff (sys_rst)
      sda_oe |-> state_r inside {smbus_temp_pkg::ST_AACK, smbus_temp_pkg::ST_CACK,
                                 smbus_temp_pkg::ST_WACK, smbus_temp_pkg::ST_RDAT};
  endproperty
  a_sda_owner: assert property (p_sda_owner) else $error("data line driven outside slot");

  property p_addr_miss;
    @(posedge clk) disable iff (sys_rst)
      (state_r == smbus_temp_pkg::ST_ADDR && byte_done && rx_r[7:1] != my_addr
       && !bus_stop && !timeout) |=> state_r == smbus_temp_pkg::ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

  property p_pointer_load;
    @(posedge clk) disable iff (sys_rst)
      (state_r == smbus_temp_pkg::ST_CMD && byte_done) |=> pointer_r == $past(rx_r[2:0]);
  endproperty
  a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

  property p_temp_fresh;
    @(posedge clk) disable iff (sys_rst)
      conv_start |=> temp_r[15:3] == $past(adc_code);
  endproperty
  a_temp_fresh: assert property (p_temp_fresh) else $error("result not captured");

  property p_temp_ro;
    @(posedge clk) disable iff (sys_rst)
      !conv_start |=> $stable(temp_r);
  endproperty
  a_temp_ro: assert property (p_temp_ro) else $error("temperature changed off tick");

  property p_shutdown_halts;
    @(posedge clk) disable iff (sys_rst)
      shutdown |-> !conv_start;
  endproperty
  a_shutdown_halts: assert property (p_shutdown_halts) else $error("converting in shutdown");

  property p_timeout_release;
    @(posedge clk) disable iff (sys_rst)
      timeout |=> state_r == smbus_temp_pkg::ST_IDLE && !sda_oe;
  endproperty
  a_timeout_release: assert property (p_timeout_release) else $error("timeout kept bus");

  property p_config_write;
    @(posedge clk) disable iff (sys_rst)
      (wr_done && !byte_idx_r && pointer_r == `PTR_CONFIG) |=> config_r == $past(rx_r);
  endproperty
  a_config_write: assert property (p_config_write) else $error("config write lost");

  property p_alarm_cause;
    @(posedge clk) disable iff (sys_rst)
      alarm_oe |-> HAS_LIMITS && (temp_r[1] || temp_r[0]);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without status");

  property p_addr_ack;
    @(posedge clk) disable iff (sys_rst)
      (state_r == smbus_temp_pkg::ST_AACK) |-> sda_oe && sda_out == 1'b0;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack missing");

  c_read:    cover property (@(posedge clk) state_r == smbus_temp_pkg::ST_RACK);
  c_cfg_wr:  cover property (@(posedge clk) wr_done && pointer_r == `PTR_CONFIG);
  c_timeout: cover property (@(posedge clk) timeout);
  c_word_wr: cover property (@(posedge clk) wr_done && byte_idx_r);
endmodule // smbus_temp_sensor_regs
`default_nettype wire

// File: common/smbus_temp_defines.svh
// constants of the smbus temperature sensor register block
`ifndef SMBUS_TEMP_DEFINES_SVH
`define SMBUS_TEMP_DEFINES_SVH

// register select codes held in the pointer register
`define PTR_TEMP       3'h0
`define PTR_CONFIG     3'h1
`define PTR_HYST       3'h2
`define PTR_LOW        3'h3
`define PTR_HIGH       3'h4

// configuration register fields and reset value
`define CFG_SHUTDOWN   0
`define CFG_FAULT_Q    1
`define CFG_TMO_DIS    7
`define CFG_RESET      8'h00

// limit register reset values (80, 75 and 10 degrees, 1/16 degree steps at bit 3)
`define HIGH_RESET     16'h2800
`define HYST_RESET     16'h2580
`define LOW_RESET      16'h0500

// answer on a read of an unmapped pointer
`define UNMAPPED_BYTE  8'hff

// timing: clock period, bus timeout and conversion period in their own units
`define CLK_PERIOD_NS  100
`define TIMEOUT_MS     25
`define CONV_PERIOD_MS 500
// least timeout rounds up, conversion period taken as printed
`define TIMEOUT_CYC    ((`TIMEOUT_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC       ((`CONV_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: common/smbus_temp_pkg.sv
// types shared by the smbus temperature sensor register block
`default_nettype none
package smbus_temp_pkg;
  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,  // waiting for a start
    ST_ADDR = 4'b0001,  // shifting in address and direction
    ST_AACK = 4'b0010,  // acknowledging the address
    ST_CMD  = 4'b0011,  // shifting in the pointer byte
    ST_CACK = 4'b0100,  // acknowledging the pointer byte
    ST_WDAT = 4'b0101,  // shifting in a data byte
    ST_WACK = 4'b0110,  // acknowledging a data byte
    ST_RDAT = 4'b0111,  // shifting out a data byte
    ST_RACK = 4'b1000   // sampling the master acknowledge
  } slave_state_t;
endpackage
`default_nettype wire

// File: core/tick_divider.sv
// timebase counter: one-cycle tick after PERIOD enabled cycles
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,   // count while high, restart from zero when low
  output logic      tick   // one-cycle pulse at the end of each period
);
  localparam int W = $clog2(PERIOD + 1);

  generate
    if (PERIOD < 2) begin : g_bad
      $error("tick_divider PERIOD must be at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_r;  // cycles counted in the current period

  // counter restarts whenever run drops so a partial period never carries over
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_r <= '0;
    end else if (cnt_r == W'(PERIOD - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // tick is a decode of the counter, so it is one cycle wide
  assign tick = run && (cnt_r == W'(PERIOD - 1));
endmodule // tick_divider
`default_nettype wire

// File: tb/smbus_master_model.sv
// bus master model driving serial clock and data toward the sensor block
`timescale 1ns/100ps
`default_nettype none
module smbus_master_model (
  input  wire logic clk,       // system clock, paces the model only
  input  wire logic sda_line,  // resolved open-drain data wire
  output logic      scl,       // serial clock, idles high between frames
  output logic      sda_drv    // high while the master pulls data low
);
  int half = 2;  // low phase is half + 3 cycles, high phase 2 * half + 2, raise it for a slow master

  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data moves three cycles after the clock fall, which covers the hold time
  task automatic bit_slot(input logic b, output logic s);
    wait_clk(3);
    sda_drv = !b;
    wait_clk(half);
    scl = 1'b1;
    wait_clk(half + 1);
    s = sda_line;
    wait_clk(half + 1);
    scl = 1'b0;
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start_cond();
    wait_clk(3);
    sda_drv = 1'b0;
    wait_clk(half);
    scl = 1'b1;
    wait_clk(half + 2);
    sda_drv = 1'b1;
    wait_clk(half + 2);
    scl = 1'b0;
  endtask

  // stop: data rises while clock is high, then the bus is left idle
  task automatic stop_cond();
    wait_clk(3);
    sda_drv = 1'b1;
    wait_clk(half);
    scl = 1'b1;
    wait_clk(half + 2);
    sda_drv = 1'b0;
    wait_clk(half + 2);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) bit_slot(b[i], nack);
    bit_slot(1'b1, nack);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(nack, s);
  endtask
endmodule // smbus_master_model
`default_nettype wire

// File: tb/smbus_temp_sensor_regs_test.sv
// self-checking bench of the smbus temperature register block
`timescale 1ns/100ps
`default_nettype none
module smbus_temp_sensor_regs_test;
  localparam int         TMO      = 200;   // shortened bus timeout
  localparam int         LIMIT    = 30000; // watchdog ceiling in cycles
  localparam logic [2:0] ADDR_TOP = 3'h4;  // fixed address bits above the pins
  localparam logic [4:0] LIM_TOP  = 5'h0b; // fixed address bits of the limit variant
  logic        clk;          // 10 MHz clock
  logic        sys_rst;      // synchronous reset
  logic        scl;          // serial clock from the master
  logic        m_drv;        // master pulls data low
  logic        sda_oe;       // device pulls data low
  logic        sda_out;      // device drive level
  wire         sda_line;     // resolved wire with pull-up
  logic [3:0]  pins;         // address select inputs
  logic [12:0] adc_code;     // converter result
  logic [15:0] rd;           // word read back
  logic        nack;         // acknowledge bit seen by the master
  logic [6:0]  dev_addr;     // slave address the register tasks talk to
  logic        lim_sda_oe;   // limit variant pulls data low
  logic        lim_alarm_oe; // limit variant alarm pin pulled low
  logic        lim_ovt_oe;   // limit variant overtemp pin pulled low
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;

  assign sda_line = !(sda_oe || lim_sda_oe || m_drv);

  smbus_temp_sensor_regs #(.TIMEOUT_CYC(TMO), .CONV_CYC(50)) dut (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_bit_zero(pins[0]), .addr_select_bit_one(pins[1]),
    .addr_select_bit_two(pins[2]), .addr_select_bit_three(pins[3]), .adc_code(adc_code),
    .conv_start(), .alarm_out(), .alarm_oe(), .overtemp_shutdown_out(), .overtemp_oe());

  // limit variant with two address pins on the same bus, at its own address
  smbus_temp_sensor_regs #(.ADDR_PINS(2), .HAS_LIMITS(1'b1), .BASE_ADDR(7'h2c),
    .TIMEOUT_CYC(TMO), .CONV_CYC(50)) dut_lim (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe(lim_sda_oe), .addr_select_bit_zero(pins[0]), .addr_select_bit_one(pins[1]),
    .addr_select_bit_two(pins[2]), .addr_select_bit_three(pins[3]), .adc_code(adc_code),
    .conv_start(), .alarm_out(), .alarm_oe(lim_alarm_oe), .overtemp_shutdown_out(),
    .overtemp_oe(lim_ovt_oe));

  smbus_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(m_drv));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic addr_phase(input logic [6:0] a, input logic rdir);
    m.start_cond();
    m.wr_byte({a, rdir}, nack);
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [15:0] d, input int n);
    addr_phase(dev_addr, 1'b0);
    m.wr_byte(ptr, nack);
    for (int i = 0; i < n; i++) m.wr_byte(d[15 - 8 * i -: 8], nack);
    m.stop_cond();
  endtask

  // pointer write, repeated start, two bytes back msb first
  task automatic reg_read(input logic [7:0] ptr, output logic [15:0] d);
    addr_phase(dev_addr, 1'b0);
    m.wr_byte(ptr, nack);
    addr_phase(dev_addr, 1'b1);
    m.rd_byte(1'b0, d[15:8]);
    m.rd_byte(1'b1, d[7:0]);
    m.stop_cond();
  endtask

  task automatic probe(input logic [6:0] a, input logic exp_nack);
    addr_phase(a, 1'b0);
    m.stop_cond();
    chk("address ack", {15'h0, exp_nack}, {15'h0, nack});
  endtask

  // park the clock low in the address ack slot and watch the data line
  task automatic hold_low(input logic kept);
    logic       s;
    logic [7:0] ab;  // address byte with the write direction
    ab = {dev_addr, 1'b0};
    m.start_cond();
    for (int i = 7; i >= 0; i--) m.bit_slot(ab[i], s);
    repeat (3) @(negedge clk);
    chk("ack drive", 16'h0001, {15'h0, sda_oe});
    repeat (TMO + 5) @(negedge clk);
    chk("timeout release", {15'h0, kept}, {15'h0, sda_oe});
    m.bit_slot(1'b1, s);
    m.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    pins = 4'ha;
    dev_addr = {ADDR_TOP, 4'ha};
    adc_code = 13'h1e70;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (120) @(negedge clk);
    chk("sda level", 16'h0000, {15'h0, sda_out});
    reg_read(8'h01, rd);
    chk("config reset", 16'h0000, rd);
    reg_read(8'h00, rd);
    chk("temp negative", {13'h1e70, 3'h0}, rd);
    reg_write(8'h00, 16'h5555, 2);
    m.half = 6;
    reg_read(8'h00, rd);
    chk("temp after write", {13'h1e70, 3'h0}, rd);
    m.half = 2;
    reg_write(8'h01, 16'h82aa, 2);
    reg_read(8'h01, rd);
    chk("config word", 16'h8200, rd);
    reg_read(8'h07, rd);
    chk("unmapped", 16'h00ff, {8'h00, rd[15:8]});
    hold_low(1'b1);
    reg_write(8'h01, 16'h0000, 1);
    hold_low(1'b0);
    reg_write(8'h01, 16'h0100, 1);
    adc_code = 13'h0123;
    repeat (150) @(negedge clk);
    reg_read(8'h00, rd);
    chk("temp frozen", {13'h1e70, 3'h0}, rd);
    reg_read(8'h01, rd);
    chk("config shutdown", 16'h0100, rd);
    reg_write(8'h01, 16'h0000, 1);
    repeat (150) @(negedge clk);
    reg_read(8'h00, rd);
    chk("temp resumed", {13'h0123, 3'h0}, rd);
    // limit variant: a high limit below the result raises both status and pins
    dev_addr = {LIM_TOP, pins[1:0]};
    reg_write(8'h04, 16'h0800, 2);
    reg_read(8'h04, rd);
    chk("high limit", 16'h0800, rd);
    reg_read(8'h00, rd);
    chk("temp status", {13'h0123, 3'h2}, rd);
    chk("alarm pins", 16'h0003, {14'h0, lim_alarm_oe, lim_ovt_oe});
    dev_addr = {ADDR_TOP, pins};
    for (int i = 0; i < 4; i++) begin
      pins = 4'h1 << i;
      probe({ADDR_TOP, pins}, 1'b0);
      probe({ADDR_TOP, 4'h0}, 1'b1);
    end
    final_report();
  end
endmodule // smbus_temp_sensor_regs_test
`default_nettype wire
